/* adccs_pkg.sv */
package adccs_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CFG_OFS = 8'h04;
    localparam logic [7:0] DIR_OFS = 8'h08;
    localparam logic [7:0] RES_OFS = 8'h0c;
    localparam logic [7:0] PORT_OFS = 8'h10;
    localparam logic [7:0] STAT_OFS = 8'h14;
    // converter_control_reg fields
    localparam int CS_HI = 7;
    localparam int CS_LO = 6;
    localparam int CH_HI = 4;
    localparam int CH_LO = 3;
    localparam int GO_BIT = 2;
    localparam int DONE_BIT = 1;
    localparam int PWR_BIT = 0;
    // clock select codes
    localparam logic [1:0] CS_DIV2 = 2'h0;
    localparam logic [1:0] CS_DIV8 = 2'h1;
    localparam logic [1:0] CS_DIV32 = 2'h2;
    localparam logic [1:0] CS_RC = 2'h3;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic [3:0] DIR_RST = 4'hf;
    localparam logic [7:0] RES_RST = 8'h00;
    localparam logic [3:0] LATCH_RST = 4'h0;
    // timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int TAD_MIN_NS = 1600;
    localparam int RC_TAD_NS = 4000;
    localparam int TAD_MIN_CYC = (TAD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RC_TAD_CYC = (RC_TAD_NS * 1000) / CLK_PERIOD_PS;
    localparam int DIV2_CYC = 2;
    localparam int DIV8_CYC = 8;
    localparam int DIV32_CYC = 32;
    // conversion phases: setup period, 8 bit periods, closing half period
    localparam logic [3:0] PH_FIRST_BIT = 4'h1;
    localparam logic [3:0] PH_LAST_BIT = 4'h8;
    localparam logic [3:0] PH_HALF = 4'h9;
    localparam logic [1:0] HOLDOFF_TADS = 2'h2;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_ACQ,
        ST_CONV,
        ST_HOLD
    } adccs_state_t;
endpackage : adccs_pkg

/* adccs_top.sv */
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - one 8-bit conversion lasts nine and a half bit periods.
// - select 00/01/10 give 2/8/32 oscillator periods per bit, 11 internal rc.
// - a selected pin driven as output converts its driven digital level.
// - port reads return zero on pins configured as analog inputs.
// - digital input pins remain convertible when selected as channel.
// - clearing go during a conversion aborts it at once.
// - an abort leaves the result register untouched.
// - after an abort wait two bit periods, then acquire again.
// - acquisition does not depend on intended resolution.
// - mid-conversion select changes accepted among divisors only, never rc.
// - total time sums each period at its current length.
// - bits after a period below minimum are flagged invalid.
// - completion loads result, clears go, sets done flag.
// - clock select at bits 7:6, go at bit 2 of control register.
module adccs_top #(
    parameter int NPINS = 4,
    parameter int RC_CYC = adccs_pkg::RC_TAD_CYC,
    parameter int MIN_CYC = adccs_pkg::TAD_MIN_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe,
    input wire logic cmp_in,
    output logic core_power,
    output logic acq_sample,
    output logic [1:0] conv_channel,
    output logic conv_from_driven,
    output logic conv_driven_level,
    output logic [7:0] sar_code,
    output logic conv_busy,
    output logic conv_done_pulse
);
    // elaboration-time parameter checks
    if (NPINS != 4) begin : g_bad_npins
        $error("adccs_top: NPINS must be 4");
    end
    if (RC_CYC < 2 || RC_CYC > 65535) begin : g_bad_rc_cyc
        $error("adccs_top: RC_CYC out of range");
    end
    if (MIN_CYC < 1 || MIN_CYC > 65535) begin : g_bad_min_cyc
        $error("adccs_top: MIN_CYC out of range");
    end

    // bit-period length in clk cycles for a select code
    function automatic logic [15:0] tad_len(input logic [1:0] sel);
        logic [15:0] len;
        len = 16'(RC_CYC);
        unique case (sel)
            adccs_pkg::CS_DIV2: len = 16'(adccs_pkg::DIV2_CYC);
            adccs_pkg::CS_DIV8: len = 16'(adccs_pkg::DIV8_CYC);
            adccs_pkg::CS_DIV32: len = 16'(adccs_pkg::DIV32_CYC);
            adccs_pkg::CS_RC: len = 16'(RC_CYC);
        endcase
        return len;
    endfunction : tad_len

    // pins reading as analog for a port configuration
    function automatic logic [3:0] analog_mask(input logic [1:0] cfg);
        logic [3:0] m;
        m = 4'hf;
        unique case (cfg)
            2'h0: m = 4'hf;
            2'h1: m = 4'hf;
            2'h2: m = 4'h3;
            2'h3: m = 4'h0;
        endcase
        return m;
    endfunction : analog_mask

    // registers
    logic [1:0] cs_q, cs_d;
    logic [1:0] ch_q;
    logic go_q, go_d;
    logic done_q, done_d;
    logic pwr_q;
    logic [1:0] cfg_q;
    logic [3:0] dir_q;
    logic [3:0] latch_q;
    logic [7:0] res_q, res_d;
    logic [7:0] invalid_q, invalid_d;
    logic [31:0] rdata_q;
    adccs_pkg::adccs_state_t state_q, state_d;
    logic [15:0] presc_q, presc_d;
    logic [3:0] phase_q, phase_d;
    logic [1:0] hold_q, hold_d;
    logic [7:0] sar_q, sar_d;
    logic bad_q, bad_d;
    logic rc_run_q, rc_run_d;
    logic [1:0] run_cs_q, run_cs_d;
    logic done_pulse_q;
    logic [3:0] pin_s1_q, pin_s2_q;

    // apb decode
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire wr_en = access_ph & pwrite;
    wire hit_ctrl = paddr == adccs_pkg::CTRL_OFS;
    wire hit_cfg = paddr == adccs_pkg::CFG_OFS;
    wire hit_dir = paddr == adccs_pkg::DIR_OFS;
    wire hit_res = paddr == adccs_pkg::RES_OFS;
    wire hit_port = paddr == adccs_pkg::PORT_OFS;
    wire hit_stat = paddr == adccs_pkg::STAT_OFS;
    wire mapped = hit_ctrl | hit_cfg | hit_dir | hit_res | hit_port | hit_stat;
    wire wr_ctrl = wr_en & hit_ctrl;
    wire wr_cfg = wr_en & hit_cfg;
    wire wr_dir = wr_en & hit_dir;
    wire wr_res = wr_en & hit_res;
    wire wr_port = wr_en & hit_port;

    assign pready = 1'b1;
    assign pslverr = access_ph & ~mapped;
    assign prdata = rdata_q;

    // port readback, analog pins forced low
    wire [3:0] amask = analog_mask(cfg_q);
    wire [3:0] port_rd = pin_s2_q & ~amask;
    wire [7:0] ctrl_rd = {cs_q, 1'b0, ch_q, go_q, done_q, pwr_q};
    wire [7:0] stat_rd = {4'h0, bad_q, conv_busy, state_q};
    wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_rd} :
                         hit_cfg ? {30'h00000000, cfg_q} :
                         hit_dir ? {28'h0000000, dir_q} :
                         hit_res ? {24'h000000, res_q} :
                         hit_port ? {28'h0000000, port_rd} :
                         hit_stat ? {16'h0000, invalid_q, stat_rd} : 32'h00000000;

    // selected channel source
    wire sel_is_output = ~dir_q[ch_q];
    assign conv_channel = ch_q;
    assign conv_from_driven = sel_is_output;
    assign conv_driven_level = latch_q[ch_q];
    assign pin_out = latch_q;
    assign pin_oe = ~dir_q;
    assign core_power = pwr_q;
    assign acq_sample = state_q == adccs_pkg::ST_ACQ;
    assign sar_code = sar_q;
    assign conv_busy = state_q == adccs_pkg::ST_CONV;
    assign conv_done_pulse = done_pulse_q;

    // software view of control fields
    wire [1:0] wr_cs = pwdata[adccs_pkg::CS_HI:adccs_pkg::CS_LO];
    wire wr_go = pwdata[adccs_pkg::GO_BIT];
    wire wr_done = pwdata[adccs_pkg::DONE_BIT];
    wire wr_pwr = pwdata[adccs_pkg::PWR_BIT];
    wire go_now = wr_ctrl ? wr_go : go_q;
    wire pwr_now = wr_ctrl ? wr_pwr : pwr_q;

    // clock select in force during a conversion
    wire cs_is_rc = cs_q == adccs_pkg::CS_RC;
    wire [1:0] eff_cs = rc_run_q ? adccs_pkg::CS_RC : (cs_is_rc ? run_cs_q : cs_q);
    wire [15:0] cur_len = tad_len(eff_cs);
    wire [15:0] half_len = (cur_len >> 1);
    wire [15:0] end_cnt = (phase_q == adccs_pkg::PH_HALF) ? half_len - 16'h0001 : cur_len - 16'h0001;
    wire period_end = presc_q >= end_cnt;
    wire below_min = cur_len < 16'(MIN_CYC);
    wire in_bit = (phase_q >= adccs_pkg::PH_FIRST_BIT) && (phase_q <= adccs_pkg::PH_LAST_BIT);
    wire [2:0] bit_idx = 3'(adccs_pkg::PH_LAST_BIT - phase_q);
    wire [7:0] bit_one = 8'h01 << bit_idx;
    wire [7:0] next_one = 8'h01 << 3'(bit_idx - 3'h1);
    wire conv_fin = (state_q == adccs_pkg::ST_CONV) && pwr_now && go_now && period_end && (phase_q == adccs_pkg::PH_HALF);

    // sequencer
    always_comb begin
        state_d = state_q;
        presc_d = presc_q;
        phase_d = phase_q;
        hold_d = hold_q;
        sar_d = sar_q;
        bad_d = bad_q;
        invalid_d = invalid_q;
        rc_run_d = rc_run_q;
        run_cs_d = run_cs_q;
        res_d = wr_res ? pwdata[7:0] : res_q;
        go_d = go_now;
        done_d = wr_ctrl ? wr_done : done_q;
        cs_d = wr_ctrl ? wr_cs : cs_q;
        unique case (state_q)
            adccs_pkg::ST_OFF: begin
                go_d = 1'b0;
                if (pwr_now) begin
                    state_d = adccs_pkg::ST_ACQ;
                end
            end
            adccs_pkg::ST_ACQ: begin
                if (!pwr_now) begin
                    state_d = adccs_pkg::ST_OFF;
                    go_d = 1'b0;
                end else if (go_q) begin
                    state_d = adccs_pkg::ST_CONV;
                    presc_d = 16'h0000;
                    phase_d = 4'h0;
                    sar_d = 8'h80;
                    bad_d = 1'b0;
                    rc_run_d = cs_is_rc;
                    run_cs_d = cs_q;
                end
            end
            adccs_pkg::ST_CONV: begin
                if (!pwr_now || !go_now) begin
                    state_d = adccs_pkg::ST_HOLD;
                    presc_d = 16'h0000;
                    phase_d = 4'h0;
                    hold_d = 2'h0;
                    go_d = 1'b0;
                end else begin
                    if (!rc_run_q && !cs_is_rc) begin
                        run_cs_d = cs_q;
                    end
                    if (below_min && in_bit) begin
                        bad_d = 1'b1;
                    end
                    if (period_end) begin
                        presc_d = 16'h0000;
                        phase_d = phase_q + 4'h1;
                        if (in_bit) begin
                            if (!cmp_in) begin
                                sar_d = sar_q & ~bit_one;
                            end
                            if (phase_q != adccs_pkg::PH_LAST_BIT) begin
                                sar_d = (cmp_in ? sar_q : (sar_q & ~bit_one)) | next_one;
                            end
                            invalid_d[bit_idx] = bad_q | below_min;
                        end
                        if (phase_q == adccs_pkg::PH_HALF) begin
                            state_d = adccs_pkg::ST_HOLD;
                            hold_d = 2'h0;
                            res_d = sar_q;
                            go_d = 1'b0;
                            done_d = 1'b1;
                        end
                    end else begin
                        presc_d = presc_q + 16'h0001;
                    end
                end
            end
            adccs_pkg::ST_HOLD: begin
                if (!pwr_now) begin
                    state_d = adccs_pkg::ST_OFF;
                    go_d = 1'b0;
                end else if (period_end) begin
                    presc_d = 16'h0000;
                    hold_d = hold_q + 2'h1;
                    if (hold_q == adccs_pkg::HOLDOFF_TADS - 2'h1) begin
                        state_d = adccs_pkg::ST_ACQ;
                    end
                end else begin
                    presc_d = presc_q + 16'h0001;
                end
            end
        endcase
    end

    // pin synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end else begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // software registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_q <= adccs_pkg::CTRL_RST[adccs_pkg::CS_HI:adccs_pkg::CS_LO];
            ch_q <= adccs_pkg::CTRL_RST[adccs_pkg::CH_HI:adccs_pkg::CH_LO];
            pwr_q <= adccs_pkg::CTRL_RST[adccs_pkg::PWR_BIT];
            cfg_q <= adccs_pkg::CFG_RST;
            dir_q <= adccs_pkg::DIR_RST;
            latch_q <= adccs_pkg::LATCH_RST;
            rdata_q <= 32'h00000000;
        end else begin
            if (wr_ctrl) begin
                cs_q <= cs_d;
                ch_q <= pwdata[adccs_pkg::CH_HI:adccs_pkg::CH_LO];
                pwr_q <= wr_pwr;
            end
            if (wr_cfg) begin
                cfg_q <= pwdata[1:0];
            end
            if (wr_dir) begin
                dir_q <= pwdata[3:0];
            end
            if (wr_port) begin
                latch_q <= pwdata[3:0];
            end
            if (setup_ph) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // sequencer and result state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= adccs_pkg::ST_OFF;
            go_q <= adccs_pkg::CTRL_RST[adccs_pkg::GO_BIT];
            done_q <= adccs_pkg::CTRL_RST[adccs_pkg::DONE_BIT];
            res_q <= adccs_pkg::RES_RST;
            invalid_q <= 8'h00;
            presc_q <= 16'h0000;
            phase_q <= 4'h0;
            hold_q <= 2'h0;
            sar_q <= 8'h00;
            bad_q <= 1'b0;
            rc_run_q <= 1'b0;
            run_cs_q <= adccs_pkg::CS_DIV2;
            done_pulse_q <= 1'b0;
        end else begin
            state_q <= state_d;
            go_q <= go_d;
            done_q <= done_d;
            res_q <= res_d;
            invalid_q <= invalid_d;
            presc_q <= presc_d;
            phase_q <= phase_d;
            hold_q <= hold_d;
            sar_q <= sar_d;
            bad_q <= bad_d;
            rc_run_q <= rc_run_d;
            run_cs_q <= run_cs_d;
            done_pulse_q <= conv_fin;
        end
    end
endmodule : adccs_top

/* adccs_props.sv */
`timescale 1ns/1ps
module adccs_props #(
    parameter int NPINS = 4,
    parameter int RC_CYC = 160
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NPINS-1:0] pin_out,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic [1:0] conv_channel,
    input wire logic conv_from_driven,
    input wire logic conv_driven_level,
    input wire logic [7:0] sar_code,
    input wire logic conv_busy,
    input wire logic acq_sample,
    input wire logic core_power,
    input wire logic conv_done_pulse
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic [1:0] cs_q;
    logic [1:0] cfg_q;
    logic [11:0] len_q;
    logic st_q;
    logic ab_q;
    wire acc = psel && penable;
    wire wr_ctl = acc && pwrite && paddr == adccs_pkg::CTRL_OFS;
    wire go_on = pwdata[adccs_pkg::GO_BIT] && pwdata[adccs_pkg::PWR_BIT];
    wire kill = wr_ctl && conv_busy && !go_on;
    wire [3:0] amask = cfg_q[1] ? (cfg_q[0] ? 4'h0 : 4'h3) : 4'hf;
    wire [11:0] exp_len = (cs_q == adccs_pkg::CS_RC) ? 12'(RC_CYC * 19 / 2) : 12'(19 << (2 * cs_q));
    wire bad_adr = paddr > adccs_pkg::STAT_OFS || paddr[1:0] != 2'h0;
    // track select, port config, busy length, abort and select changes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_q <= 2'h0;
            cfg_q <= 2'h0;
            len_q <= 12'h0;
            st_q <= 1'b0;
            ab_q <= 1'b0;
        end else begin
            if (wr_ctl) cs_q <= pwdata[7:6];
            if (acc && pwrite && paddr == adccs_pkg::CFG_OFS) cfg_q <= pwdata[1:0];
            len_q <= conv_busy ? len_q + 12'h1 : 12'h0;
            if ($rose(conv_busy)) begin
                st_q <= 1'b1;
                ab_q <= 1'b0;
            end else begin
                if (wr_ctl && conv_busy && pwdata[7:6] != cs_q) st_q <= 1'b0;
                if (kill) ab_q <= 1'b1;
            end
        end
    end
    property p_len; $fell(conv_busy) && st_q && !ab_q |-> len_q == exp_len; endproperty
    a_len: assert property (p_len) else $error("conversion length wrong");
    property p_done; $fell(conv_busy) && !ab_q |-> ##[0:1] conv_done_pulse; endproperty
    a_done: assert property (p_done) else $error("no done pulse");
    property p_pulse; conv_done_pulse |=> !conv_done_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("done pulse too long");
    property p_noload; $fell(conv_busy) && ab_q |-> !conv_done_pulse [*3]; endproperty
    a_noload: assert property (p_noload) else $error("done after abort");
    property p_abort; kill |-> ##[1:2] !conv_busy; endproperty
    a_abort: assert property (p_abort) else $error("abort not taken");
    property p_hold; $fell(conv_busy) && core_power && st_q && cs_q == 2'h0 |-> !acq_sample [*4] ##1 acq_sample; endproperty
    a_hold: assert property (p_hold) else $error("holdoff length wrong");
    property p_sar; $rose(conv_busy) |-> sar_code == 8'h80; endproperty
    a_sar: assert property (p_sar) else $error("trial code start wrong");
    property p_port; acc && !pwrite && paddr == adccs_pkg::PORT_OFS |-> (prdata[3:0] & amask) == 4'h0; endproperty
    a_port: assert property (p_port) else $error("analog pin read not zero");
    property p_drv; conv_busy |-> conv_from_driven == pin_oe[conv_channel] && conv_driven_level == pin_out[conv_channel]; endproperty
    a_drv: assert property (p_drv) else $error("driven pin source wrong");
    property p_ready; acc |-> pready && pslverr == bad_adr; endproperty
    a_ready: assert property (p_ready) else $error("bus answer wrong");
    c_done: cover property (conv_done_pulse);
    c_abort: cover property ($fell(conv_busy) && ab_q);
    c_err: cover property (acc && pslverr);
endmodule : adccs_props

/* adccs_core_model.sv */
`timescale 1ns/1ps
module adccs_core_model (
    input wire logic clk,
    input wire logic acq_sample,
    input wire logic [1:0] conv_channel,
    input wire logic conv_from_driven,
    input wire logic conv_driven_level,
    input wire logic [7:0] sar_code,
    input wire logic [31:0] ain,
    output logic cmp_in
);
    logic [7:0] hold_q = 8'h00;
    wire [7:0] pin_lvl = ain[conv_channel * 8 +: 8];
    wire [7:0] src = conv_from_driven ? {8{conv_driven_level}} : pin_lvl;
    // hold capacitor follows the pin only while connected
    always @(posedge clk) begin
        if (acq_sample) hold_q <= src;
    end
    assign cmp_in = hold_q >= sar_code;
endmodule : adccs_core_model

/* tb_adccs_top.sv */
`timescale 1ns/1ps
module tb_adccs_top;
    localparam int NPINS = 4;
    localparam int RC_CYC = 20;
    localparam int MIN_CYC = 16;
    localparam logic [7:0] CTL = adccs_pkg::CTRL_OFS;
    localparam logic [7:0] RES = adccs_pkg::RES_OFS;
    localparam logic [7:0] PRT = adccs_pkg::PORT_OFS;
    localparam logic [7:0] DIR = adccs_pkg::DIR_OFS;
    localparam logic [7:0] CFG = adccs_pkg::CFG_OFS;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pin_in = 4'h0;
    logic [31:0] ain = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, cmp_in, core_power, acq_sample, conv_from_driven;
    logic conv_driven_level, conv_busy, conv_done_pulse;
    logic [3:0] pin_out, pin_oe;
    logic [1:0] conv_channel, c;
    logic [7:0] sar_code, v;
    integer seed = 32'h8d0cdd1d;
    int n_mismatch = 0;
    int n_compared = 0;
    int len;
    adccs_top #(.NPINS(NPINS), .RC_CYC(RC_CYC), .MIN_CYC(MIN_CYC)) uut (.clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .cmp_in, .core_power, .acq_sample,
        .conv_channel, .conv_from_driven, .conv_driven_level, .sar_code, .conv_busy, .conv_done_pulse);
    adccs_core_model core (.clk, .acq_sample, .conv_channel, .conv_from_driven, .conv_driven_level, .sar_code,
        .ain, .cmp_in);
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] ctl(logic [1:0] s, logic [1:0] ch, logic g);
        return {24'h0, s, 1'b0, ch, g, 2'b01};
    endfunction : ctl
    function automatic logic [31:0] tlen(logic [1:0] s);
        return (s == 2'h3) ? 32'(RC_CYC * 19 / 2) : 32'(19 << (2 * s));
    endfunction : tlen
    function automatic logic [31:0] tmask(logic [1:0] s);
        return ((s == 2'h3 ? RC_CYC : 2 << (2 * s)) < MIN_CYC) ? 32'hff : 32'h0;
    endfunction : tmask
    task test_done;
        if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t expected %h got %h", $time, e, g);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            test_done;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task conv(input logic [1:0] s, input logic [1:0] ch);
        apb(1'b1, CTL, ctl(s, ch, 1'b0));
        apb(1'b1, CTL, ctl(s, ch, 1'b1));
    endtask : conv
    task idle;
        int i;
        len = 0;
        for (i = 0; i < 2000; i++) begin
            @(posedge clk);
            #1;
            if (conv_busy === 1'b1) len++;
            else if (len > 0) break;
        end
        if (i == 2000) begin
            n_mismatch++;
            test_done;
        end
    endtask : idle
    initial begin
        int s;
        int b;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, CTL, 32'h0);
        chk(adccs_pkg::CTRL_RST, rd);
        apb(1'b0, DIR, 32'h0);
        chk(adccs_pkg::DIR_RST, rd);
        apb(1'b0, RES, 32'h0);
        chk(adccs_pkg::RES_RST, rd);
        apb(1'b1, 8'h18, 32'hffffffff);
        apb(1'b0, 8'h18, 32'h0);
        chk(32'h1, err);
        chk(32'h0, rd);
        for (s = 0; s < 4; s++) begin
            c = 2'($random(seed));
            ain <= $random(seed);
            conv(2'(s), c);
            idle;
            chk(tlen(2'(s)), len);
            apb(1'b0, RES, 32'h0);
            chk(ain[c * 8 +: 8], rd);
            apb(1'b0, CTL, 32'h0);
            chk(ctl(2'(s), c, 1'b0) | 32'h2, rd);
            apb(1'b0, adccs_pkg::STAT_OFS, 32'h0);
            chk(tmask(2'(s)), rd[15:8]);
        end
        apb(1'b1, DIR, 32'he);
        for (b = 0; b < 2; b++) begin
            apb(1'b1, PRT, b);
            conv(2'h0, 2'h0);
            idle;
            apb(1'b0, RES, 32'h0);
            chk(b ? 32'hff : 32'h0, rd);
        end
        apb(1'b1, DIR, 32'hf);
        pin_in <= 4'($random(seed));
        ain <= $random(seed);
        apb(1'b1, CFG, 32'h3);
        apb(1'b0, PRT, 32'h0);
        chk(pin_in, rd);
        apb(1'b1, CFG, 32'h2);
        apb(1'b0, PRT, 32'h0);
        chk({pin_in[3:2], 2'b00}, rd);
        conv(2'h0, 2'h3);
        idle;
        apb(1'b0, RES, 32'h0);
        chk(ain[31:24], rd);
        v = 8'($random(seed));
        apb(1'b1, RES, {24'h0, v});
        conv(2'h0, 2'h1);
        repeat (6) @(posedge clk);
        apb(1'b1, CTL, ctl(2'h0, 2'h1, 1'b0));
        repeat (2) @(posedge clk);
        #1;
        chk(32'h0, conv_busy);
        apb(1'b0, RES, 32'h0);
        chk(v, rd);
        apb(1'b0, CTL, 32'h0);
        chk(ctl(2'h0, 2'h1, 1'b0), rd);
        conv(2'h2, 2'h2);
        repeat (164) @(posedge clk);
        apb(1'b1, CTL, ctl(2'h0, 2'h2, 1'b1));
        idle;
        chk(32'h1, 32'(len < 20));
        apb(1'b0, RES, 32'h0);
        chk(ain[23:16], rd);
        apb(1'b0, adccs_pkg::STAT_OFS, 32'h0);
        chk(32'h0f, rd[15:8]);
        conv(2'h3, 2'h0);
        repeat (20) @(posedge clk);
        apb(1'b1, CTL, ctl(2'h0, 2'h0, 1'b1));
        idle;
        chk(tlen(2'h3), len + 23);
        test_done;
    end
endmodule : tb_adccs_top
bind adccs_top adccs_props #(.NPINS(NPINS), .RC_CYC(RC_CYC)) u_props (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin_out, .pin_oe, .conv_channel, .conv_from_driven, .conv_driven_level,
    .sar_code, .conv_busy, .acq_sample, .core_power, .conv_done_pulse);
